// ### include/fiarg_pkg.sv
// package for the flash region guard: map, codes, timing
// assumes a 250 MHz system clock and a 32-bit APB register port
//
// Functional notes
// - flash spans 0000h..1FFFh, 8 KiB
// - of the top sixteen bytes, 1FFDh and 1FFBh load controls at power-on
// - 0000h..007Fh reserved for vector table
// - 1F00h..1FEFh always writable
// - single byte writes need no erase
// - unlock flag clear after any reset; the code clears it on rst only, por leaves it as it was
// - 0000h..1EFFh writable only when unlocked
// - command code 65h sets unlock flag
// - any other command value clears unlock
// - top byte 1FFFh never writable
// - config low and trim writable when unlocked
// - power-on loads config low and trim
// - 1FF0h/1FF1h hold stored code checksum
// - writes need enable flag, code 47h
// - stall processor about 0.5 ms per write
// - command register reads unlock on bit 0
package fiarg_pkg;
    // flash geometry
    localparam int FL_AW = 13;
    localparam int FL_DEPTH = 8192;
    localparam logic [15:0] FL_LAST = 16'h1FFF;
    // regions
    localparam logic [15:0] VEC_LAST = 16'h007F;
    localparam logic [15:0] PROG_LAST = 16'h1EFF;
    localparam logic [15:0] FREE_FIRST = 16'h1F00;
    localparam logic [15:0] FREE_LAST = 16'h1FEF;
    localparam logic [15:0] CFG_FIRST = 16'h1FF0;
    localparam logic [15:0] CSUM_LO = 16'h1FF0;
    localparam logic [15:0] CSUM_HI = 16'h1FF1;
    localparam logic [15:0] CFG_BG = 16'h1FFB;
    localparam logic [15:0] CFG_LOW = 16'h1FFD;
    localparam logic [15:0] CFG_HIGH = 16'h1FFF;
    localparam logic [15:0] EMU_FIRST = 16'h0D00;
    localparam logic [15:0] EMU_LAST = 16'h0FFF;
    // command codes
    localparam logic [7:0] UNLOCK_CODE = 8'h65;
    localparam logic [7:0] WREN_CODE = 8'h47;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_WREN = 8'h04;
    localparam logic [7:0] OFS_CFGLOW = 8'h08;
    localparam logic [7:0] OFS_BGTRIM = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // field positions
    localparam int UNLOCK_BIT = 0;
    localparam int WREN_BIT = 7;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LOADED_BIT = 1;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    // write time
    localparam int CLK_PERIOD_NS = 4;
    localparam int WR_TIME_NS = 500000;
    localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 17;
    // configuration load sequencer
    typedef enum logic [1:0] {
        FIARG_IDLE = 2'b00,
        FIARG_LD_LOW = 2'b01,
        FIARG_LD_BG = 2'b10,
        FIARG_LD_FIN = 2'b11
    } fiarg_ld_e;
endpackage

// ### rtl/fiarg_store.sv
// flash byte array with one registered read port and one write port
// assumes writes are already vetted by the guard
`timescale 1ns/1ns
`default_nettype none
module fiarg_store (
    // clocking
    input wire logic clk,
    input wire logic ce,
    // read port
    input wire logic rd_en,
    input wire logic [fiarg_pkg::FL_AW-1:0] rd_addr,
    output logic [7:0] rd_data,
    // write port
    input wire logic wr_en,
    input wire logic [fiarg_pkg::FL_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data
);
    import fiarg_pkg::*;
    // array content survives reset, like real flash
    logic [7:0] mem [0:FL_DEPTH-1];
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    // next read word, held when idle
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            rd_data_nxt = mem[rd_addr];
        end
    end
    // byte program overwrites in place, no erase step
    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data_r <= rd_data_nxt;
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
        end
    end
    assign rd_data = rd_data_r;
endmodule // fiarg_store
`default_nettype wire

// ### rtl/fiarg_wtimer.sv
// program-time counter: busy for a fixed count after a start pulse
// assumes start only arrives while idle
`timescale 1ns/1ns
`default_nettype none
module fiarg_wtimer #(
    parameter logic [16:0] CYCLES = 17'd125000
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // control
    input wire logic start,
    output logic busy
);
    import fiarg_pkg::*;
    logic [TMR_W-1:0] cnt_r;
    logic [TMR_W-1:0] cnt_nxt;
    // load on start, count down to zero
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = CYCLES;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end
    // register stage
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end
    assign busy = (cnt_r != '0);
endmodule // fiarg_wtimer
`default_nettype wire

// ### rtl/fiarg_guard.sv
// flash region guard: access rules, unlock and enable flags,
// power-on configuration load, APB register slave
// assumes CPU requests and APB are synchronous to clk
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module fiarg_guard #(
    parameter logic [16:0] WR_CYC = 17'(fiarg_pkg::WR_CYCLES)
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic por,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // code read port
    input wire logic code_req,
    input wire logic [fiarg_pkg::FL_AW-1:0] code_addr,
    output logic code_ready,
    output logic code_valid,
    output logic [7:0] code_rdata,
    // data write port
    input wire logic iap_req,
    input wire logic [15:0] iap_addr,
    input wire logic [7:0] iap_wdata,
    output logic cpu_stall,
    // mode and loaded controls
    input wire logic emu_mode,
    output logic [7:0] config_word_low,
    output logic [7:0] bandgap_trim_byte
);
    import fiarg_pkg::*;

    // flags and control registers
    logic whole_array_unlock_r; // unlock flag
    logic whole_array_unlock_nxt;
    logic flash_write_enable_flag_r; // program enable
    logic flash_write_enable_flag_nxt;
    logic [7:0] cfg_low_r; // config low copy
    logic [7:0] cfg_low_nxt;
    logic [7:0] bg_trim_r; // trim copy
    logic [7:0] bg_trim_nxt;
    logic loaded_r; // power-on copy finished
    logic loaded_nxt;
    fiarg_ld_e ld_r; // load sequencer
    fiarg_ld_e ld_nxt;

    // apb outputs
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;

    // code read outputs
    logic code_valid_r;
    logic code_valid_nxt;

    // store and timer wiring
    logic st_rd_en;
    logic [FL_AW-1:0] st_rd_addr;
    logic [7:0] st_rd_data;
    logic st_wr_en;
    logic wr_busy;

    // decoded bus strobes
    logic apb_wr;
    logic [7:0] ofs;
    logic loading;
    logic allowed;

    assign ofs = paddr[7:0];
    // access phase; zero wait states so every access ends here
    assign apb_wr = psel & penable & pwrite;
    assign loading = (ld_r != FIARG_IDLE);

    // address permission for an in-application write
    always_comb begin
        allowed = 1'b0;
        if (iap_addr > FL_LAST) begin
            allowed = 1'b0; // outside the array
        end else if (iap_addr == CFG_HIGH) begin
            allowed = 1'b0;
        end else if (iap_addr >= CFG_FIRST) begin
            // checksum, trim and config low bytes
            allowed = whole_array_unlock_r;
        end else if (iap_addr >= FREE_FIRST) begin
            allowed = 1'b1;
        end else if (emu_mode && iap_addr >= EMU_FIRST && iap_addr <= EMU_LAST) begin
            allowed = 1'b0;
        end else begin
            // program area incl. vectors
            allowed = whole_array_unlock_r;
        end
    end

    // a write proceeds only with enable set, idle and permitted;
    // anything else is dropped with no flag or error
    assign st_wr_en = iap_req & flash_write_enable_flag_r & allowed
        & ~wr_busy & ~loading;

    // stall the cpu for the program time; peripherals are not
    // touched since only the cpu sees this signal
    assign cpu_stall = wr_busy | st_wr_en;

    // store read address: load sequencer wins over code reads
    always_comb begin
        st_rd_en = 1'b0;
        st_rd_addr = code_addr;
        case (ld_r)
            FIARG_LD_LOW: begin
                st_rd_en = 1'b1;
                st_rd_addr = CFG_LOW[FL_AW-1:0];
            end
            FIARG_LD_BG: begin
                st_rd_en = 1'b1;
                st_rd_addr = CFG_BG[FL_AW-1:0];
            end
            FIARG_LD_FIN: begin
                st_rd_en = 1'b0;
            end
            default: begin
                // any address, unlock flag not consulted
                st_rd_en = code_req;
            end
        endcase
    end

    // code read handshake: refused only while loading
    assign code_ready = ~loading;
    assign code_valid_nxt = code_req & ~loading;

    // load sequencer and loaded copies
    always_comb begin
        ld_nxt = ld_r;
        cfg_low_nxt = cfg_low_r;
        bg_trim_nxt = bg_trim_r;
        loaded_nxt = loaded_r;
        case (ld_r)
            FIARG_IDLE: begin
                if (por) begin
                    ld_nxt = FIARG_LD_LOW;
                    loaded_nxt = 1'b0;
                end
            end
            FIARG_LD_LOW: begin
                ld_nxt = FIARG_LD_BG;
            end
            FIARG_LD_BG: begin
                cfg_low_nxt = st_rd_data;
                ld_nxt = FIARG_LD_FIN;
            end
            FIARG_LD_FIN: begin
                bg_trim_nxt = st_rd_data;
                loaded_nxt = 1'b1;
                ld_nxt = FIARG_IDLE;
            end
            default: begin
                ld_nxt = FIARG_IDLE;
            end
        endcase
        // software can overwrite the copies whenever no load is running
        if (!loading && apb_wr && ofs == OFS_CFGLOW) begin
            cfg_low_nxt = pwdata[7:0];
        end
        if (!loading && apb_wr && ofs == OFS_BGTRIM) begin
            bg_trim_nxt = pwdata[7:0];
        end
    end

    // command and enable flags written by software
    always_comb begin
        whole_array_unlock_nxt = whole_array_unlock_r;
        flash_write_enable_flag_nxt = flash_write_enable_flag_r;
        if (apb_wr && ofs == OFS_CMD) begin
            // only the exact code unlocks; any other value locks
            whole_array_unlock_nxt = (pwdata[7:0] == UNLOCK_CODE);
        end
        if (apb_wr && ofs == OFS_WREN) begin
            flash_write_enable_flag_nxt = (pwdata[7:0] == WREN_CODE);
        end
    end

    // apb read mux and error answer
    always_comb begin
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        if (psel && !penable) begin
            prdata_nxt = '0;
            if (!pwrite) begin
                case (ofs)
                    OFS_CMD: prdata_nxt[UNLOCK_BIT] = whole_array_unlock_r;
                    OFS_WREN: prdata_nxt[WREN_BIT] = flash_write_enable_flag_r;
                    OFS_CFGLOW: prdata_nxt[7:0] = cfg_low_r;
                    OFS_BGTRIM: prdata_nxt[7:0] = bg_trim_r;
                    OFS_STATUS: begin
                        prdata_nxt[ST_BUSY_BIT] = wr_busy;
                        prdata_nxt[ST_LOADED_BIT] = loaded_r;
                    end
                    default: prdata_nxt = '0;
                endcase
            end
        end
        if (paddr[31:8] != '0 || paddr[1:0] != 2'b00) begin
            pslverr_nxt = 1'b1;
        end else begin
            case (ofs)
                OFS_CMD, OFS_WREN, OFS_CFGLOW, OFS_BGTRIM: pslverr_nxt = 1'b0;
                OFS_STATUS: pslverr_nxt = pwrite;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    // register stage; ce low freezes everything
    always_ff @(posedge clk) begin
        if (rst) begin
            whole_array_unlock_r <= 1'b0;
            flash_write_enable_flag_r <= 1'b0;
            cfg_low_r <= CFG_RST;
            bg_trim_r <= CFG_RST;
            loaded_r <= 1'b0;
            ld_r <= FIARG_IDLE;
            prdata_r <= '0;
            code_valid_r <= 1'b0;
        end else if (ce) begin
            whole_array_unlock_r <= whole_array_unlock_nxt;
            flash_write_enable_flag_r <= flash_write_enable_flag_nxt;
            cfg_low_r <= cfg_low_nxt;
            bg_trim_r <= bg_trim_nxt;
            loaded_r <= loaded_nxt;
            ld_r <= ld_nxt;
            prdata_r <= prdata_nxt;
            code_valid_r <= code_valid_nxt;
        end
    end

    // error is combinational on the access phase
    assign pready = 1'b1;
    assign pslverr = psel & penable & pslverr_nxt;
    assign prdata = prdata_r;
    assign code_valid = code_valid_r;
    assign code_rdata = st_rd_data;
    assign config_word_low = cfg_low_r;
    assign bandgap_trim_byte = bg_trim_r;

    // flash array
    fiarg_store u_store (
        .clk(clk),
        .ce(ce),
        .rd_en(st_rd_en),
        .rd_addr(st_rd_addr),
        .rd_data(st_rd_data),
        .wr_en(st_wr_en),
        .wr_addr(iap_addr[FL_AW-1:0]),
        .wr_data(iap_wdata)
    );

    // program-time counter
    fiarg_wtimer #(
        .CYCLES(WR_CYC)
    ) u_wtimer (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .start(st_wr_en),
        .busy(wr_busy)
    );
endmodule // fiarg_guard
`default_nettype wire

// ### tb/fiarg_guard_chk.sv
// checker for the flash region guard, bound to its top
// assumes one clock, sync reset, and a clock enable held high
`timescale 1ns/1ns
`default_nettype none
module fiarg_guard_chk import fiarg_pkg::*; #(
    parameter logic [16:0] WR_CYC = 17'd20
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic por,
    // register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // cpu side
    input wire logic code_req,
    input wire logic code_ready,
    input wire logic code_valid,
    input wire logic iap_req,
    input wire logic [15:0] iap_addr,
    input wire logic cpu_stall,
    input wire logic emu_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic unl_r, unl_nxt; // shadow of the unlock flag
    logic wen_r, wen_nxt; // shadow of the write enable flag
    logic [17:0] cnt_r, cnt_nxt; // stall run length
    logic wtake; // register write taken this cycle
    // shadows follow software writes, so the checker needs no internal probe
    always_comb begin
        wtake = psel && penable && pwrite;
        unl_nxt = unl_r;
        wen_nxt = wen_r;
        if (wtake && paddr == 32'h0) begin
            unl_nxt = (pwdata[7:0] == UNLOCK_CODE);
        end
        if (wtake && paddr == 32'h4) begin
            wen_nxt = (pwdata[7:0] == WREN_CODE);
        end
        cnt_nxt = cpu_stall ? cnt_r + 18'h1 : 18'h0;
    end
    // register the shadows
    always_ff @(posedge clk) begin
        if (rst) begin
            unl_r <= 1'b0;
            wen_r <= 1'b0;
            cnt_r <= 18'h0;
        end else begin
            unl_r <= unl_nxt;
            wen_r <= wen_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    AST_STALL_LEN: assert property ($fell(cpu_stall) |-> cnt_r == 18'(WR_CYC) + 18'h1)
        else $error("stall length wrong");
    AST_CODE_ANS: assert property (code_req && code_ready |=> code_valid)
        else $error("code read not answered");
    AST_CODE_IDLE: assert property (!(code_req && code_ready) |=> !code_valid)
        else $error("code answer without request");
    AST_LOAD: assert property (por && code_ready |=> !code_ready [*3] ##1 code_ready)
        else $error("config load length wrong");
    AST_TOP_LOCK: assert property (iap_req && iap_addr >= CFG_HIGH && !$past(cpu_stall) |-> !cpu_stall)
        else $error("top byte write taken");
    AST_PROG_LOCK: assert property (iap_req && iap_addr <= PROG_LAST && !unl_r && !$past(cpu_stall)
        |-> !cpu_stall)
        else $error("locked program write taken");
    AST_EMU: assert property (iap_req && emu_mode && iap_addr >= EMU_FIRST && iap_addr <= EMU_LAST
        && !$past(cpu_stall) |-> !cpu_stall)
        else $error("emulator area write taken");
    AST_WREN: assert property (iap_req && !wen_r && !$past(cpu_stall) |-> !cpu_stall)
        else $error("write taken while disabled");
    AST_FREE: assert property (iap_req && wen_r && code_ready && iap_addr >= FREE_FIRST
        && iap_addr <= FREE_LAST && !$past(cpu_stall) |-> cpu_stall)
        else $error("free area write refused");
    AST_UNL_RD: assert property (psel && penable && !pwrite && paddr == 32'h0
        |-> prdata[UNLOCK_BIT] == unl_r)
        else $error("unlock read back wrong");
    AST_BAD_ADDR: assert property (psel && penable && paddr == 32'h14 |-> pslverr)
        else $error("unmapped access not flagged");
endmodule // fiarg_guard_chk
bind fiarg_guard fiarg_guard_chk #(.WR_CYC(WR_CYC)) u_fiarg_guard_chk (
    .clk(clk), .rst(rst), .por(por), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .code_req(code_req),
    .code_ready(code_ready), .code_valid(code_valid), .iap_req(iap_req), .iap_addr(iap_addr),
    .cpu_stall(cpu_stall), .emu_mode(emu_mode)
);
`default_nettype wire

// ### tb/fiarg_cpu_model.sv
// cpu core model: code fetches and byte writes into flash
// assumes the caller issues one request at a time
`timescale 1ns/1ns
`default_nettype none
module fiarg_cpu_model (
    // clock
    input wire logic clk,
    // code read side
    output logic code_req,
    output logic [fiarg_pkg::FL_AW-1:0] code_addr,
    input wire logic code_valid,
    input wire logic [7:0] code_rdata,
    // byte write side
    output logic iap_req,
    output logic [15:0] iap_addr,
    output logic [7:0] iap_wdata,
    input wire logic cpu_stall
);
    import fiarg_pkg::*;
    // idle at time zero
    initial begin
        code_req = 1'b0;
        code_addr = '0;
        iap_req = 1'b0;
        iap_addr = 16'h0;
        iap_wdata = 8'h0;
    end
    // one-cycle write pulse; n counts stall cycles, 0 when refused
    task automatic wr(input logic [15:0] a, input logic [7:0] d, output int n);
        n = 0;
        @(posedge clk);
        iap_req <= 1'b1;
        iap_addr <= a;
        iap_wdata <= d;
        @(negedge clk);
        // the core waits while stalled, as the real one would
        while (cpu_stall === 1'b1 && n < 200) begin
            n++;
            @(posedge clk);
            iap_req <= 1'b0;
            @(negedge clk);
        end
        @(posedge clk);
        iap_req <= 1'b0;
        // released lines show no stale value
        iap_addr <= ~a;
        iap_wdata <= ~d;
    endtask
    // code fetch: answer one cycle after the request is taken
    task automatic rd(input logic [FL_AW-1:0] a, output logic [7:0] d);
        @(posedge clk);
        code_req <= 1'b1;
        code_addr <= a;
        @(posedge clk);
        code_req <= 1'b0;
        code_addr <= ~a;
        @(negedge clk);
        d = (code_valid === 1'b1) ? code_rdata : 8'hXX;
    endtask
endmodule // fiarg_cpu_model
`default_nettype wire

// ### tb/tb_fiarg_guard.sv
// testbench for the flash region guard
// assumes the checker is bound by its own file
`timescale 1ns/1ns
`default_nettype none
module tb_fiarg_guard;
    import fiarg_pkg::*;
    localparam logic [16:0] WR = 17'd20; // shortened write time
    localparam int TK = 21; // stall cycles of a taken write
    localparam int LIMIT = 20000; // hang ceiling in cycles
    logic clk, rst, ce, por, psel, penable, pwrite, emu_mode;
    logic [31:0] paddr, pwdata, prdata;
    logic pready, pslverr, code_req, code_ready, code_valid, iap_req, cpu_stall;
    logic [12:0] code_addr;
    logic [15:0] iap_addr;
    logic [7:0] code_rdata, iap_wdata, config_word_low, bandgap_trim_byte;
    int n_fail, num_checks, cyc;
    fiarg_guard #(.WR_CYC(WR)) u_fiarg_guard (
        .clk(clk), .rst(rst), .ce(ce), .por(por), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .code_req(code_req), .code_addr(code_addr), .code_ready(code_ready),
        .code_valid(code_valid), .code_rdata(code_rdata), .iap_req(iap_req), .iap_addr(iap_addr),
        .iap_wdata(iap_wdata), .cpu_stall(cpu_stall), .emu_mode(emu_mode),
        .config_word_low(config_word_low), .bandgap_trim_byte(bandgap_trim_byte)
    );
    fiarg_cpu_model u_fiarg_cpu_model (
        .clk(clk), .code_req(code_req), .code_addr(code_addr), .code_valid(code_valid),
        .code_rdata(code_rdata), .iap_req(iap_req), .iap_addr(iap_addr),
        .iap_wdata(iap_wdata), .cpu_stall(cpu_stall)
    );
    // 250 MHz
    always #2 clk = ~clk;
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb transfer: hold the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the bench timeout ends this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic reg_r(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask
    task automatic wrc(input logic [15:0] a, input logic [7:0] d, input int exp_n);
        int n;
        u_fiarg_cpu_model.wr(a, d, n);
        chk(32'(n), 32'(exp_n));
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_fiarg_cpu_model.rd(a, d);
        chk({24'h0, d}, {24'h0, exp});
    endtask
    // every register zero after reset, unmapped and read-only places refused
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++) begin
            reg_r(8'(4 * i), 32'h0);
        end
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h1, r, e);
        chk({31'h0, e}, 32'h1);
        $display("done: reset");
    endtask
    // free area always writable, byte overwrite without erase
    task automatic t_free;
        reg_w(OFS_WREN, WREN_CODE);
        wrc(16'h1F00, 8'h5A, TK);
        wrc(16'h1FEF, 8'hA5, TK);
        wrc(16'h1F00, 8'hC3, TK);
        rdc(13'h1F00, 8'hC3);
        rdc(13'h1FEF, 8'hA5);
        $display("done: free area");
    endtask
    // unlock, guarded writes, lock again; refused writes change nothing
    task automatic t_unlock;
        reg_w(OFS_CMD, UNLOCK_CODE);
        reg_r(OFS_CMD, 32'h1);
        wrc(16'h0000, 8'h11, TK);
        wrc(16'h1EFF, 8'h22, TK);
        wrc(16'h1FFD, 8'h3C, TK);
        wrc(16'h1FFB, 8'hC5, TK);
        wrc(16'h1FFF, 8'h77, 0);
        wrc(16'h2000, 8'h77, 0);
        reg_w(OFS_CMD, 8'h66);
        reg_r(OFS_CMD, 32'h0);
        wrc(16'h1EFF, 8'h99, 0);
        wrc(16'h1FF0, 8'h99, 0);
        wrc(16'h1FFD, 8'h00, 0);
        rdc(13'h1EFF, 8'h22);
        rdc(13'h0000, 8'h11);
        rdc(13'h1FFD, 8'h3C);
        $display("done: unlock");
    endtask
    // power-on copy of config bytes, then software override
    task automatic t_por;
        @(posedge clk);
        por <= 1'b1;
        @(posedge clk);
        por <= 1'b0;
        repeat (6) @(posedge clk);
        chk({24'h0, config_word_low}, 32'h3C);
        chk({24'h0, bandgap_trim_byte}, 32'hC5);
        reg_r(OFS_STATUS, 32'h2);
        reg_r(OFS_BGTRIM, 32'hC5);
        reg_w(OFS_CFGLOW, 8'h81);
        reg_r(OFS_CFGLOW, 32'h81);
        chk({24'h0, config_word_low}, 32'h81);
        $display("done: power-on load");
    endtask
    // write enable flag gates every write
    task automatic t_wren;
        reg_w(OFS_WREN, 8'h00);
        reg_r(OFS_WREN, 32'h0);
        wrc(16'h1F20, 8'h44, 0);
        reg_w(OFS_WREN, WREN_CODE);
        reg_r(OFS_WREN, 32'h80);
        $display("done: write enable");
    endtask
    // emulator area kept free even when unlocked
    task automatic t_emu;
        reg_w(OFS_CMD, UNLOCK_CODE);
        @(posedge clk);
        emu_mode <= 1'b1;
        wrc(16'h0E00, 8'h55, 0);
        wrc(16'h0CFF, 8'h55, TK);
        emu_mode <= 1'b0;
        $display("done: emulation");
    endtask
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        por = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        emu_mode = 1'b0;
        n_fail = 0;
        num_checks = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_free();
        t_unlock();
        t_por();
        t_wren();
        t_emu();
        test_done();
    end
endmodule // tb_fiarg_guard
`default_nettype wire
